// File: hdl/eeprom_cfg.svh
// Constants for the two-wire serial EEPROM target: frame layout, paging, timing.
// Assumes a 25 MHz ref_clk and a separate free-running link sampling clock.
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH

`define DEV_TYPE_CODE 4'ha
`define BYTE_BITS 8
`define ACK_SLOT 4'h8
`define FRAME_END 4'h9
`define PAGE_BYTES 32
`define PAGE_IDX_BITS 5
`define ADDR_BITS_SMALL 12
`define ADDR_BITS_LARGE 13
`define REF_CLK_HZ 25000000
`define INTERNAL_WRITE_TIME_MS 10
`define INTERNAL_WRITE_CYCLES ((`INTERNAL_WRITE_TIME_MS * `REF_CLK_HZ) / 1000)

`endif

// File: hdl/eeprom_pkg.sv
// Types shared by the serial EEPROM target.
// Assumes the constants header is included by each user.
package eeprom_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV_ADDR,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WR_DATA,
    ST_RD_DATA
  } link_state_t;

endpackage

// File: hdl/write_cycle_timer.sv
// Self-timed nonvolatile write cycle, counted on ref_clk.
// Assumes req_toggle comes from the link domain; done_toggle is read there through a synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_cfg.svh"

module write_cycle_timer #(
  parameter int CYCLES = `INTERNAL_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Crossing
  input wire logic req_toggle,
  output logic done_toggle
);

  logic req_meta;
  logic req_sync;
  logic req_prev;
  logic running;
  logic [31:0] count;
  logic next_req_prev;
  logic next_running;
  logic [31:0] next_count;
  logic next_done_toggle;

  always_comb begin
    next_req_prev = req_sync;
    next_running = running;
    next_count = count;
    next_done_toggle = done_toggle;
    if (req_sync != req_prev) begin
      next_running = 1'b1;
      next_count = 32'h0;
    end else if (running) begin
      if (count == 32'(CYCLES - 1)) begin
        next_running = 1'b0;
        next_done_toggle = ~done_toggle;
      end else begin
        next_count = count + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    req_meta <= req_toggle;
    req_sync <= req_meta;
    if (rst) begin
      req_prev <= 1'b0;
      running <= 1'b0;
      count <= 32'h0;
      done_toggle <= 1'b0;
    end else begin
      req_prev <= next_req_prev;
      running <= next_running;
      count <= next_count;
      done_toggle <= next_done_toggle;
    end
  end

endmodule
`default_nettype wire

// File: hdl/serial_eeprom.sv
// Two-wire serial EEPROM target: addressing, page write, reads, write-cycle busy.
// Assumes link_clk oversamples scl and sda well above the bus rate; sda is open drain,
// pulled high outside; rst is synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_cfg.svh"

module serial_eeprom
  import eeprom_pkg::*;
#(
  parameter int ADDR_BITS = `ADDR_BITS_LARGE,
  parameter int WRITE_CYCLES = `INTERNAL_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link sampling clock
  input wire logic link_clk,
  // Bus pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Straps
  input wire logic [2:0] strap_select_pins,
  // Status
  output logic write_in_progress
);

  localparam int MEM_BYTES = 1 << ADDR_BITS;

  // Link-domain synchronisers
  logic rst_meta;
  logic link_rst;
  logic scl_meta;
  logic scl_sync;
  logic scl_prev;
  logic sda_meta;
  logic sda_sync;
  logic sda_prev;
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;
  logic done_meta;
  logic done_sync;
  logic done_prev;
  logic done_toggle;

  // Bus events
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic write_done;

  // Engine state
  link_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic drive_low;
  logic [ADDR_BITS-1:0] word_addr;
  logic host_ack;
  logic is_read;
  logic data_seen;
  logic busy;
  logic req_toggle;
  link_state_t next_state;
  logic [3:0] next_bit_cnt;
  logic [7:0] next_shift;
  logic next_drive_low;
  logic [ADDR_BITS-1:0] next_word_addr;
  logic next_host_ack;
  logic next_is_read;
  logic next_data_seen;
  logic next_busy;
  logic next_req_toggle;

  // Page buffer and array
  logic [7:0] page_buf [`PAGE_BYTES];
  logic [`PAGE_BYTES-1:0] page_dirty;
  logic [ADDR_BITS-`PAGE_IDX_BITS-1:0] page_row;
  logic [7:0] mem [MEM_BYTES];
  logic buf_we;
  logic buf_clear;
  logic [`PAGE_IDX_BITS-1:0] buf_idx;
  logic [7:0] rd_byte;
  logic addr_match;

  // The first stage of each synchroniser feeds only the second stage
  always_ff @(posedge link_clk) begin
    rst_meta <= rst;
    link_rst <= rst_meta;
    scl_meta <= scl;
    scl_sync <= scl_meta;
    scl_prev <= scl_sync;
    sda_meta <= sda_in;
    sda_sync <= sda_meta;
    sda_prev <= sda_sync;
    strap_meta <= strap_select_pins;
    strap_sync <= strap_meta;
    done_meta <= done_toggle;
    done_sync <= done_meta;
    done_prev <= done_sync;
  end

  assign scl_rise = scl_sync & ~scl_prev;
  assign scl_fall = ~scl_sync & scl_prev;
  assign start_cond = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_cond = scl_sync & scl_prev & ~sda_prev & sda_sync;
  assign write_done = done_sync ^ done_prev;
  assign rd_byte = mem[word_addr];

  // type code and select match; direction bit not compared; no answer while busy
  assign addr_match = (shift[7:4] == `DEV_TYPE_CODE) && (shift[3:1] == strap_sync) && !busy;

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_drive_low = drive_low;
    next_word_addr = word_addr;
    next_host_ack = host_ack;
    next_is_read = is_read;
    next_data_seen = data_seen;
    next_busy = busy;
    next_req_toggle = req_toggle;
    buf_we = 1'b0;
    buf_clear = 1'b0;
    buf_idx = word_addr[`PAGE_IDX_BITS-1:0];
    // busy clears once the timed write has landed
    if (write_done) begin
      next_busy = 1'b0;
      buf_clear = 1'b1;
    end
    if (start_cond) begin
      next_state = ST_DEV_ADDR;
      next_bit_cnt = 4'h0;
      next_drive_low = 1'b0;
      // An unterminated write is abandoned, not committed
      if (!busy) begin
        buf_clear = 1'b1;
      end
    end else if (stop_cond) begin
      next_state = ST_IDLE;
      next_drive_low = 1'b0;
      // stop after data starts the write
      if (state == ST_WR_DATA && data_seen && !busy) begin
        next_busy = 1'b1;
        next_req_toggle = ~req_toggle;
      end
    end else if (scl_rise && state != ST_IDLE) begin
      if (bit_cnt < `ACK_SLOT && state != ST_RD_DATA) begin
        next_shift = {shift[6:0], sda_sync};
      end
      // host acknowledge sampled on the ninth clock
      if (bit_cnt == `ACK_SLOT && state == ST_RD_DATA) begin
        next_host_ack = ~sda_sync;
      end
      if (bit_cnt < `FRAME_END) begin
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end else if (scl_fall && state != ST_IDLE) begin
      if (bit_cnt == `ACK_SLOT) begin
        unique case (state)
          ST_DEV_ADDR: begin
            if (addr_match) begin
              next_drive_low = 1'b1;
              next_is_read = shift[0];
            end else begin
              next_state = ST_IDLE;
            end
          end
          ST_ADDR_HI: begin
            // high word address byte; upper bits dropped
            next_drive_low = 1'b1;
            next_word_addr = {shift[ADDR_BITS-`BYTE_BITS-1:0], word_addr[7:0]};
          end
          ST_ADDR_LO: begin
            next_drive_low = 1'b1;
            next_word_addr = {word_addr[ADDR_BITS-1:8], shift};
          end
          ST_WR_DATA: begin
            next_drive_low = 1'b1;
            buf_we = 1'b1;
            next_data_seen = 1'b1;
            // low bits only; wrap in page
            next_word_addr = {word_addr[ADDR_BITS-1:`PAGE_IDX_BITS],
                              word_addr[`PAGE_IDX_BITS-1:0] + 5'h1};
          end
          ST_RD_DATA: begin
            next_drive_low = 1'b0;
          end
          default: begin
            next_state = ST_IDLE;
          end
        endcase
      end else if (bit_cnt == `FRAME_END) begin
        next_bit_cnt = 4'h0;
        next_drive_low = 1'b0;
        unique case (state)
          ST_DEV_ADDR: begin
            // direction bit one selects read; counter byte out
            if (is_read) begin
              next_state = ST_RD_DATA;
              next_shift = rd_byte;
              next_drive_low = ~rd_byte[7];
              // counter left at last read plus one; full wrap
              next_word_addr = word_addr + 1'b1;
            end else begin
              next_state = ST_ADDR_HI;
            end
          end
          ST_ADDR_HI: begin
            next_state = ST_ADDR_LO;
          end
          ST_ADDR_LO: begin
            // repeated start here turns this into a random read
            next_state = ST_WR_DATA;
            next_data_seen = 1'b0;
          end
          ST_WR_DATA: begin
            next_state = ST_WR_DATA;
          end
          ST_RD_DATA: begin
            // acknowledged read sends the next byte
            if (host_ack) begin
              next_shift = rd_byte;
              next_drive_low = ~rd_byte[7];
              next_word_addr = word_addr + 1'b1;
            end else begin
              next_state = ST_IDLE;
            end
          end
          default: begin
            next_state = ST_IDLE;
          end
        endcase
      end else if (state == ST_RD_DATA && bit_cnt != 4'h0) begin
        next_shift = {shift[6:0], 1'b0};
        next_drive_low = ~shift[6];
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      drive_low <= 1'b0;
      word_addr <= '0;
      host_ack <= 1'b0;
      is_read <= 1'b0;
      data_seen <= 1'b0;
      busy <= 1'b0;
      req_toggle <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      drive_low <= next_drive_low;
      word_addr <= next_word_addr;
      host_ack <= next_host_ack;
      is_read <= next_is_read;
      data_seen <= next_data_seen;
      busy <= next_busy;
      req_toggle <= next_req_toggle;
    end
  end

  // Page buffer collects the bytes; a later byte at the same index overwrites the earlier one
  always_ff @(posedge link_clk) begin
    if (link_rst || buf_clear) begin
      page_dirty <= '0;
    end else if (buf_we) begin
      page_buf[buf_idx] <= shift;
      page_dirty[buf_idx] <= 1'b1;
      page_row <= word_addr[ADDR_BITS-1:`PAGE_IDX_BITS];
    end
  end

  // Array has no reset: contents survive rst as a nonvolatile store would
  always_ff @(posedge link_clk) begin
    if (write_done) begin
      for (int i = 0; i < `PAGE_BYTES; i++) begin
        if (page_dirty[i]) begin
          mem[{page_row, 5'(i)}] <= page_buf[i];
        end
      end
    end
  end

  write_cycle_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .req_toggle(req_toggle),
    .done_toggle(done_toggle)
  );

  // acknowledge and data are driven lows only
  assign sda_out = 1'b0;
  assign sda_oe = drive_low;
  assign write_in_progress = busy;

endmodule
`default_nettype wire

// File: testbench/serial_eeprom_props.sv
// Checker for the serial EEPROM target, bound to its top module.
// Assumes a pulled-up sda and a host holding scl low phases of 8 link cycles or more.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_props #(
  parameter int WRITE_CYCLES = 250000
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_clk,
  // Bus pins
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Straps and status
  input wire logic [2:0] strap_select_pins,
  input wire logic write_in_progress
);
  logic [31:0] busy_cnt;
  logic [31:0] next_busy_cnt;
  always_comb begin
    next_busy_cnt = write_in_progress ? busy_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge ref_clk) begin
    busy_cnt <= rst ? 32'h0 : next_busy_cnt;
  end
  sequence s_stop;
    scl && $rose(sda_in);
  endsequence
  sequence s_quiet;
    !sda_oe [*8];
  endsequence
  property p_open_drain;
    @(posedge link_clk) disable iff (rst) sda_oe |-> !sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");
  property p_oe_scl_low;
    @(posedge link_clk) disable iff (rst) $changed(sda_oe) |-> !scl;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda drive changed with scl high");
  property p_oe_hold;
    @(posedge link_clk) disable iff (rst) $rose(sda_oe) |=> sda_oe [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("low bit shorter than a bit time");
  property p_stop_quiet;
    @(posedge link_clk) disable iff (rst) s_stop |-> s_quiet;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("sda driven after stop");
  property p_busy_rise;
    @(posedge link_clk) disable iff (rst) $rose(write_in_progress) |-> scl;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("write began away from stop");
  property p_busy_quiet;
    @(posedge link_clk) disable iff (rst) write_in_progress |-> !sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("answer during write cycle");
  property p_wr_max;
    @(posedge ref_clk) disable iff (rst) busy_cnt <= WRITE_CYCLES + 16;
  endproperty
  a_wr_max: assert property (p_wr_max) else $error("write cycle too long");
  property p_wr_min;
    @(posedge ref_clk) disable iff (rst) $fell(write_in_progress) |-> busy_cnt >= WRITE_CYCLES;
  endproperty
  a_wr_min: assert property (p_wr_min) else $error("write cycle too short");
endmodule
bind serial_eeprom serial_eeprom_props #(.WRITE_CYCLES(WRITE_CYCLES)) props_u (.ref_clk(ref_clk), .rst(rst),
  .link_clk(link_clk), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .strap_select_pins(strap_select_pins), .write_in_progress(write_in_progress));
`default_nettype wire

// File: testbench/bus_host.sv
// Behavioural two-wire bus host with adjustable scl half period.
// Assumes sda is the wired level; releasing means driving 1 into the pull-up.
`timescale 1ns/1ps
`default_nettype none
module bus_host (
  // Clock
  input wire logic link_clk,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  int half = 12;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  // data moves only while scl is low
  task automatic clk_bit(input logic v, output logic s);
    tick(2);
    sda_drv = v;
    tick(half);
    scl = 1'b1;
    tick(half / 2);
    s = sda;
    tick(half - half / 2);
    scl = 1'b0;
  endtask
  task automatic start();
    tick(2);
    sda_drv = 1'b1;
    tick(half);
    scl = 1'b1;
    tick(half);
    sda_drv = 1'b0;
    tick(half);
    scl = 1'b0;
  endtask
  // stop leaves scl high, so the bus clock stands still
  task automatic stop();
    tick(2);
    sda_drv = 1'b0;
    tick(half);
    scl = 1'b1;
    tick(half);
    sda_drv = 1'b1;
    tick(half);
  endtask
  // MSB first, then the ninth clock for the ack
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  // host acks to continue, withholds on the last byte
  task automatic rd_byte(output logic [7:0] b, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
    clk_bit(!ack, s);
  endtask
endmodule
`default_nettype wire

// File: testbench/serial_eeprom_tb.sv
// Self-checking bench: mismatch, page write with wrap, polling, reads.
// Assumes bus_host drives the bus; sda is wired-and with a pull-up.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_cfg.svh"
module serial_eeprom_tb;
  localparam int WC = 2000;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] straps = 3'h5;
  logic [7:0] mem [0:8191];
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 98787;
  wire logic scl, sda_drv, sda_out, sda_oe, write_in_progress;
  wire logic sda = sda_drv & ~(sda_oe & ~sda_out);
  initial forever #20 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #16 link_clk = ~link_clk;
  end
  serial_eeprom #(.ADDR_BITS(13), .WRITE_CYCLES(WC)) dut_u (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .strap_select_pins(straps),
    .write_in_progress(write_in_progress));
  bus_host host_u (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    // An unknown byte never counts as a match, even against an unknown expectation
    if (seen !== exp || $isunknown(seen)) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Writes wrap inside the page
  function automatic logic [12:0] wr_addr(input logic [12:0] base, input int i);
    return {base[12:5], base[4:0] + 5'(i)};
  endfunction
  task automatic addr(input logic rd, input logic [2:0] sel, output logic a);
    host_u.start();
    host_u.wr_byte({`DEV_TYPE_CODE, sel, rd}, a);
  endtask
  task automatic send(input logic [7:0] b);
    logic a;
    host_u.wr_byte(b, a);
    check("byte ack", {7'h0, a}, 8'h1);
  endtask
  task automatic set_addr(input logic [12:0] base);
    logic a;
    addr(1'b0, straps, a);
    check("address ack", {7'h0, a}, 8'h1);
    send({3'($random(seed)), base[12:8]});
    send(base[7:0]);
  endtask
  task automatic write_seq(input logic [12:0] base, input int n);
    logic a;
    logic [7:0] d;
    set_addr(base);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      send(d);
      mem[wr_addr(base, i)] = d;
    end
    host_u.stop();
    check("busy", {7'h0, write_in_progress}, 8'h1);
    addr(1'b0, straps, a);
    check("busy ack", {7'h0, a}, 8'h0);
    for (int i = 0; i < 40 && a !== 1'b1; i++) addr(1'b1, straps, a);
    if (a !== 1'b1) begin
      mismatches++;
      stop_test();
    end
    host_u.rd_byte(d, 1'b0);
    host_u.stop();
    check("current read", d, mem[wr_addr(base, n)]);
  endtask
  task automatic read_seq(input logic [12:0] base, input int n);
    logic a;
    logic [7:0] d;
    set_addr(base);
    addr(1'b1, straps, a);
    check("read ack", {7'h0, a}, 8'h1);
    for (int i = 0; i < n; i++) begin
      host_u.rd_byte(d, i < n - 1);
      check("read data", d, mem[13'(base + 13'(i))]);
    end
    host_u.stop();
  endtask
  initial begin
    logic a;
    logic [12:0] b;
    straps = 3'($random(seed));
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (6) @(posedge link_clk);
    #1;
    check("idle busy", {7'h0, write_in_progress}, 8'h0);
    addr(1'b0, straps ^ 3'h2, a);
    check("mismatch ack", {7'h0, a}, 8'h0);
    host_u.stop();
    // Every byte read back must have been written: the array has no reset value
    b = {8'hff, 5'($random(seed))};
    write_seq(b, 34);
    // Slower host on the read-back
    host_u.half = 20;
    read_seq({b[12:5], 5'h00}, 32);
    host_u.half = 12;
    write_seq(13'h1fff, 1);
    write_seq(13'h0000, 32);
    read_seq(13'h1fff, 2);
    for (int k = 0; k < 3; k++) begin
      b = {(k == 1) ? 8'h00 : 8'hff, 5'($random(seed) & 15)};
      write_seq(b, 1 + k * 3);
      read_seq(b, 1 + k * 3);
    end
    stop_test();
  end
endmodule
`default_nettype wire
